// ### hdl/dual_uart_register_decode.sv
// How it works
// [RL1] Two identical independent channel register sets
// [RL2] Frame is start through stop bits
// [RL3] Character payload five to eight bits
// [RL4] Offset 0 reads receive, writes transmit
// [RL5] Divisor access: offset 0 is divisor low
// [RL6] Divisor access: offset 1 is divisor high
// [RL7] Other offsets decoded as documented map
// [RL8] Multi-function pin selectable, general after reset
// [RL9] Reset clears controls, line status 0x60
`timescale 1ns/1ps
`default_nettype none

module dual_uart_register_decode (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic channel_select_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic [1:0] rx_push_i,
  input wire logic [1:0][7:0] rx_data_i,
  input wire logic [1:0][2:0] rx_error_i,
  input wire logic [1:0] tx_taken_i,
  input wire logic [1:0] tx_idle_i,
  output wire logic [1:0] tx_load_o,
  output wire logic [1:0][7:0] tx_data_o,
  input wire logic [1:0][3:0] modem_n_i,
  output wire logic [1:0] rts_n_o,
  output wire logic [1:0] dtr_n_o,
  output wire logic [1:0] multi_function_o,
  output wire logic [1:0] set_break_o,
  output wire logic [1:0][3:0] char_bits_o,
  output wire logic [1:0][3:0] frame_bits_o,
  output wire logic [1:0][15:0] divisor_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared bus decode

  wire logic chan_idx;
  wire logic bus_rd;
  wire logic bus_wr;
  wire logic [7:0] chan_rd_data [2];
  wire logic concurrent_of [2];
  wire logic concurrent_sel;

  // Select high reaches the first set (index 0), low the second
  assign chan_idx = ~channel_select_i;
  assign bus_rd = cs_i & rd_i;
  assign bus_wr = cs_i & wr_i;
  assign concurrent_sel = concurrent_of[chan_idx];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= bus_rd;
      if (bus_rd) begin
        rd_data_o <= chan_rd_data[chan_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel register sets

  // [RL1] Replicated channel sets
  for (genvar c = 0; c < 2; c++) begin : chan
    logic [7:0] line_control, modem_control, scratch_pad, dll, divisor_high, rxb, tx_holding, fifo_control;
    logic [3:0] interrupt_enable;
    logic [2:0] alternate_function;
    logic [6:0] line_status;
    logic [3:0] msr_delta, msr_prev;
    logic [3:0] modem_meta, modem_sync;
    logic tx_load_q, mf_q, rts_n_q, dtr_n_q, brk_q;
    logic [3:0] char_q, frame_q;
    wire logic baud, divisor_access_bit, mine, wr_en, rd_en;
    wire logic wr_thr, rd_rbr, wr_dll, wr_dlm, wr_ier, wr_fcr, wr_afr;
    wire logic wr_lcr, wr_mcr, wr_scr, rd_lsr, rd_msr, loop;
    wire logic [7:0] char_mask, lsr_full, interrupt_ident, msr_full;
    wire logic [3:0] modem_now, char_bits, frame_bits, iir_code;
    wire logic line_int, rx_int, thre_int, modem_int;
    wire logic [15:0] divisor;
    wire dual_uart_pkg::mf_sel_t mf_sel;

    assign divisor_access_bit = line_control[dual_uart_pkg::LCR_DIV_ACCESS];
    assign mine = (chan_idx == 1'(c));
    // Concurrent write mirrors a write to the selected set into both
    assign wr_en = bus_wr & (mine | concurrent_sel);
    assign rd_en = bus_rd & mine;
    assign concurrent_of[c] = alternate_function[dual_uart_pkg::AFR_CONCURRENT];
    assign loop = modem_control[dual_uart_pkg::MCR_LOOP];

    // [RL4] Data offset with divisor access clear
    assign wr_thr = wr_en & (addr_i == dual_uart_pkg::ADDR_DATA) & ~divisor_access_bit;
    assign rd_rbr = rd_en & (addr_i == dual_uart_pkg::ADDR_DATA) & ~divisor_access_bit;
    // [RL5] Divisor low byte
    assign wr_dll = wr_en & (addr_i == dual_uart_pkg::ADDR_DATA) & divisor_access_bit;
    // [RL6] Divisor high byte
    assign wr_dlm = wr_en & (addr_i == dual_uart_pkg::ADDR_IER) & divisor_access_bit;
    // [RL7] Remaining write decode
    assign wr_ier = wr_en & (addr_i == dual_uart_pkg::ADDR_IER) & ~divisor_access_bit;
    assign wr_fcr = wr_en & (addr_i == dual_uart_pkg::ADDR_IIR) & ~divisor_access_bit;
    assign wr_afr = wr_en & (addr_i == dual_uart_pkg::ADDR_IIR) & divisor_access_bit;
    assign wr_lcr = wr_en & (addr_i == dual_uart_pkg::ADDR_LCR);
    assign wr_mcr = wr_en & (addr_i == dual_uart_pkg::ADDR_MCR);
    assign wr_scr = wr_en & (addr_i == dual_uart_pkg::ADDR_SCR);
    assign rd_lsr = rd_en & (addr_i == dual_uart_pkg::ADDR_LSR);
    assign rd_msr = rd_en & (addr_i == dual_uart_pkg::ADDR_MSR);

    // [RL3] Payload width from word length field
    assign char_bits = dual_uart_pkg::CHAR_MIN_BITS + {2'h0, line_control[1:0]};
    assign char_mask = 8'hFF >> (2'h3 - line_control[1:0]);
    // [RL2] Start, payload, parity and stop bits counted
    assign frame_bits = dual_uart_pkg::START_BITS + char_bits + {3'h0, line_control[dual_uart_pkg::LCR_PARITY_EN]}
                        + (line_control[dual_uart_pkg::LCR_STOP_BITS] ? 4'h2 : 4'h1);

    assign divisor = {divisor_high, dll};
    assign lsr_full = {fifo_control[dual_uart_pkg::FCR_FIFO_EN] & (|line_status[4:2]), line_status};

    // Loopback feeds the modem controls back as status
    assign modem_now = loop ? {modem_control[dual_uart_pkg::MCR_GENERAL_OUTPUT_TWO], modem_control[dual_uart_pkg::MCR_OUT1],
                               modem_control[dual_uart_pkg::MCR_DTR], modem_control[dual_uart_pkg::MCR_RTS]}
                            : ~modem_sync;
    assign msr_full = {modem_now, msr_delta};

    assign line_int = interrupt_enable[dual_uart_pkg::IER_LINE] & (|line_status[4:1]);
    assign rx_int = interrupt_enable[dual_uart_pkg::IER_RX_DATA] & line_status[dual_uart_pkg::LSR_DATA_READY];
    assign thre_int = interrupt_enable[dual_uart_pkg::IER_TX_EMPTY] & line_status[dual_uart_pkg::LSR_THR_EMPTY];
    assign modem_int = interrupt_enable[dual_uart_pkg::IER_MODEM] & (|msr_delta);
    assign iir_code = line_int ? dual_uart_pkg::IIR_LINE
                    : rx_int ? dual_uart_pkg::IIR_RX_DATA
                    : thre_int ? dual_uart_pkg::IIR_TX_EMPTY
                    : modem_int ? dual_uart_pkg::IIR_MODEM
                    : dual_uart_pkg::IIR_NONE;
    assign interrupt_ident = {{2{fifo_control[dual_uart_pkg::FCR_FIFO_EN]}}, 2'h0, iir_code};

    // [RL7] Read selection by offset and divisor access
    assign chan_rd_data[c] = (addr_i == dual_uart_pkg::ADDR_DATA) ? (divisor_access_bit ? dll : rxb)
                           : (addr_i == dual_uart_pkg::ADDR_IER) ? (divisor_access_bit ? divisor_high : {4'h0, interrupt_enable})
                           : (addr_i == dual_uart_pkg::ADDR_IIR) ? (divisor_access_bit ? {5'h00, alternate_function} : interrupt_ident)
                           : (addr_i == dual_uart_pkg::ADDR_LCR) ? line_control
                           : (addr_i == dual_uart_pkg::ADDR_MCR) ? modem_control
                           : (addr_i == dual_uart_pkg::ADDR_LSR) ? lsr_full
                           : (addr_i == dual_uart_pkg::ADDR_MSR) ? msr_full
                           : scratch_pad;

    // [RL8] Pin function from alternate function bits 2..1
    assign mf_sel = dual_uart_pkg::mf_sel_t'(alternate_function[2:1]);

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // [RL9] Controls clear on master reset
    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        interrupt_enable <= dual_uart_pkg::CTRL_RESET[3:0];
        fifo_control <= dual_uart_pkg::CTRL_RESET;
        line_control <= dual_uart_pkg::CTRL_RESET;
        modem_control <= dual_uart_pkg::CTRL_RESET;
        alternate_function <= dual_uart_pkg::CTRL_RESET[2:0];
      end else if (ce_i) begin
        if (wr_ier) interrupt_enable <= wr_data_i[3:0];
        // FIFO reset bits are self-clearing
        if (wr_fcr) fifo_control <= wr_data_i & ~8'h06;
        if (wr_lcr) line_control <= wr_data_i;
        if (wr_mcr) modem_control <= wr_data_i;
        if (wr_afr) alternate_function <= wr_data_i[2:0];
      end
    end

    // Data and divisor kept by reset too, so nothing reads unknown
    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        dll <= dual_uart_pkg::DIVISOR_RESET[7:0];
        divisor_high <= dual_uart_pkg::DIVISOR_RESET[15:8];
        scratch_pad <= dual_uart_pkg::CTRL_RESET;
        tx_holding <= dual_uart_pkg::CTRL_RESET;
        tx_load_q <= 1'b0;
      end else if (ce_i) begin
        // [RL5] Divisor low write
        if (wr_dll) dll <= wr_data_i;
        // [RL6] Divisor high write
        if (wr_dlm) divisor_high <= wr_data_i;
        if (wr_scr) scratch_pad <= wr_data_i;
        // [RL4] Transmit holding load, trimmed to payload
        if (wr_thr) tx_holding <= wr_data_i & char_mask;
        tx_load_q <= wr_thr;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and line status; a set always beats a clear

    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        rxb <= dual_uart_pkg::CTRL_RESET;
        // [RL9] Both transmitter empty bits set
        line_status <= dual_uart_pkg::LSR_RESET[6:0];
      end else if (ce_i) begin
        // [RL3] Received payload trimmed to width
        if (rx_push_i[c]) rxb <= rx_data_i[c] & char_mask;
        line_status[dual_uart_pkg::LSR_DATA_READY] <= rx_push_i[c] | (line_status[dual_uart_pkg::LSR_DATA_READY] & ~rd_rbr);
        line_status[dual_uart_pkg::LSR_OVERRUN] <= (rx_push_i[c] & line_status[dual_uart_pkg::LSR_DATA_READY] & ~rd_rbr)
                                          | (line_status[dual_uart_pkg::LSR_OVERRUN] & ~rd_lsr);
        line_status[4:2] <= (rx_push_i[c] ? rx_error_i[c] : 3'h0) | (line_status[4:2] & ~{3{rd_lsr}});
        line_status[dual_uart_pkg::LSR_THR_EMPTY] <= tx_taken_i[c] | (line_status[dual_uart_pkg::LSR_THR_EMPTY] & ~wr_thr);
        line_status[dual_uart_pkg::LSR_TX_EMPTY] <= tx_idle_i[c] | (line_status[dual_uart_pkg::LSR_TX_EMPTY] & ~wr_thr);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modem status; pins pass two flops before use

    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        modem_meta <= 4'hF;
        modem_sync <= 4'hF;
        msr_prev <= 4'h0;
        msr_delta <= 4'h0;
      end else if (ce_i) begin
        modem_meta <= modem_n_i[c];
        modem_sync <= modem_meta;
        msr_prev <= modem_now;
        // Ring delta fires only on the trailing edge of a ring
        msr_delta <= ({modem_now[3] ^ msr_prev[3], msr_prev[2] & ~modem_now[2], modem_now[1:0] ^ msr_prev[1:0]})
                     | (msr_delta & ~{4{rd_msr}});
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs, registered

    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        // [RL8] General output, inactive high, after reset
        mf_q <= 1'b1;
        rts_n_q <= 1'b1;
        dtr_n_q <= 1'b1;
        brk_q <= 1'b0;
        char_q <= dual_uart_pkg::CHAR_MIN_BITS;
        frame_q <= 4'h7;
      end else if (ce_i) begin
        // [RL8] Function select on the multi-function pin
        case (mf_sel)
          dual_uart_pkg::MF_GENERAL: mf_q <= loop | ~modem_control[dual_uart_pkg::MCR_GENERAL_OUTPUT_TWO];
          dual_uart_pkg::MF_BAUD: mf_q <= baud;
          default: mf_q <= ~line_status[dual_uart_pkg::LSR_DATA_READY];
        endcase
        rts_n_q <= loop | ~modem_control[dual_uart_pkg::MCR_RTS];
        dtr_n_q <= loop | ~modem_control[dual_uart_pkg::MCR_DTR];
        brk_q <= line_control[dual_uart_pkg::LCR_SET_BREAK];
        char_q <= char_bits;
        frame_q <= frame_bits;
      end
    end

    baud_clock_gen u_baud (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .divisor_i(divisor),
      .baud_o(baud)
    );

    assign tx_load_o[c] = tx_load_q;
    assign tx_data_o[c] = tx_holding;
    assign rts_n_o[c] = rts_n_q;
    assign dtr_n_o[c] = dtr_n_q;
    assign multi_function_o[c] = mf_q;
    assign set_break_o[c] = brk_q;
    assign char_bits_o[c] = char_q;
    assign frame_bits_o[c] = frame_q;
    assign divisor_o[c] = divisor;
  end

endmodule // dual_uart_register_decode

`default_nettype wire

// ### pkg/dual_uart_pkg.sv
package dual_uart_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on address lines 2..0
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LCR_DIV_ACCESS = 7;
  localparam int LCR_SET_BREAK = 6;
  localparam int LCR_PARITY_EN = 3;
  localparam int LCR_STOP_BITS = 2;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_GENERAL_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;
  localparam int IER_RX_DATA = 0;
  localparam int IER_TX_EMPTY = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_RX_RESET = 1;
  localparam int FCR_TX_RESET = 2;
  localparam int LSR_DATA_READY = 0;
  localparam int LSR_OVERRUN = 1;
  localparam int LSR_THR_EMPTY = 5;
  localparam int LSR_TX_EMPTY = 6;
  localparam int AFR_CONCURRENT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LSR_RESET = 8'h60;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt identification codes, highest priority first
  localparam logic [3:0] IIR_LINE = 4'h6;
  localparam logic [3:0] IIR_RX_DATA = 4'h4;
  localparam logic [3:0] IIR_TX_EMPTY = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;
  localparam logic [3:0] IIR_NONE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Frame composition
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [3:0] CHAR_MIN_BITS = 4'h5;

  // Multi-function pin selection, alternate function bits 2..1
  typedef enum logic [1:0] {
    MF_GENERAL = 2'h0,
    MF_BAUD = 2'h1,
    MF_RX_READY = 2'h2,
    MF_RX_READY_ALT = 2'h3
  } mf_sel_t;

endpackage

// ### hdl/baud_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none

module baud_clock_gen (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [15:0] divisor_i,
  output logic baud_o
);

  logic [15:0] count;
  logic [15:0] next_count;
  wire logic [15:0] half;

  assign half = {1'b0, divisor_i[15:1]};

  // Reload at zero or when the count is at or above the divisor, so a smaller divisor takes effect at once
  always_comb begin
    next_count = count;
    if (divisor_i == 16'h0000) begin
      next_count = 16'h0000;
    end else if (count == 16'h0000 || count >= divisor_i) begin
      next_count = divisor_i - 16'h0001;
    end else begin
      next_count = count - 16'h0001;
    end
  end

  // Divisor zero stops the clock low; divisor one holds it high
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      count <= 16'h0000;
      baud_o <= 1'b0;
    end else if (ce_i) begin
      count <= next_count;
      baud_o <= (divisor_i != 16'h0000) && (next_count >= half);
    end
  end

endmodule // baud_clock_gen

`default_nettype wire

// ### bench/dual_uart_register_decode_checker.sv
`timescale 1ns/1ps
`default_nettype none

module dual_uart_register_decode_checker (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic channel_select_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_valid_o,
  input wire logic [1:0] tx_load_o,
  input wire logic [1:0] multi_function_o,
  input wire logic [1:0] set_break_o,
  input wire logic [1:0][3:0] char_bits_o,
  input wire logic [1:0][3:0] frame_bits_o,
  input wire logic [1:0][15:0] divisor_o
);
  // Shadow of each channel's divisor access bit, needed to know where offset 0 and 1 go
  logic [1:0] divisor_access_bit;
  wire logic take_rd = ce_i && cs_i && rd_i;
  wire logic take_wr = ce_i && cs_i && wr_i;
  wire logic divisor_access_bit_sel = divisor_access_bit[~channel_select_i];
  wire logic tx_wr = take_wr && addr_i == 3'h0 && !divisor_access_bit_sel;
  wire logic [1:0] wr_sel = channel_select_i ? 2'h1 : 2'h2;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      divisor_access_bit <= 2'h0;
    end else if (take_wr && addr_i == 3'h3) begin
      divisor_access_bit[~channel_select_i] <= wr_data_i[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_read;
    take_rd;
  endsequence

  sequence s_write(logic [2:0] a, logic d);
    take_wr && addr_i == a && divisor_access_bit_sel == d;
  endsequence

  a_read_answer: assert property (s_read |=> rd_valid_o) else $error("read not answered");
  a_valid_cause: assert property (rd_valid_o |-> $past(take_rd)) else $error("stray read valid");
  a_tx_load: assert property (s_write(3'h0, 1'b0) |=> tx_load_o == $past(wr_sel)) else $error("no tx load");
  a_load_cause: assert property (|tx_load_o |-> $past(tx_wr)) else $error("stray tx load");
  a_divisor_low: assert property (s_write(3'h0, 1'b1) |=>
    (($past(channel_select_i) ? divisor_o[0][7:0] : divisor_o[1][7:0]) == $past(wr_data_i)))
    else $error("divisor low wrong");
  a_divisor_high: assert property (s_write(3'h1, 1'b1) |=>
    (($past(channel_select_i) ? divisor_o[0][15:8] : divisor_o[1][15:8]) == $past(wr_data_i)))
    else $error("divisor high wrong");
  a_reset_values: assert property ($rose(reset_n_i) |-> set_break_o == 2'h0 && multi_function_o == 2'h3
    && char_bits_o[0] == 4'h5 && char_bits_o[1] == 4'h5) else $error("bad reset values");
  a_char_range: assert property (char_bits_o[0] inside {[4'h5:4'h8]}
    && char_bits_o[1] inside {[4'h5:4'h8]}) else $error("word length out of range");
  a_frame_range: assert property (frame_bits_o[0] >= char_bits_o[0] + 4'h2
    && frame_bits_o[0] <= char_bits_o[0] + 4'h4) else $error("frame length out of range");
endmodule // dual_uart_register_decode_checker

bind dual_uart_register_decode dual_uart_register_decode_checker chk (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .ce_i(ce_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i), .channel_select_i(channel_select_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o), .tx_load_o(tx_load_o), .multi_function_o(multi_function_o),
  .set_break_o(set_break_o), .char_bits_o(char_bits_o), .frame_bits_o(frame_bits_o), .divisor_o(divisor_o));

`default_nettype wire

// ### bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input wire logic clock_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output var logic cs_o,
  output var logic rd_o,
  output var logic wr_o,
  output var logic chsel_o,
  output var logic [2:0] addr_o,
  output var logic [7:0] wdata_o
);
  initial begin
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    chsel_o = 1'b0;
    addr_o = 3'h0;
    wdata_o = 8'h00;
  end

  // Held across the taking edge; released address and data lines show the inverse so stale values never look valid
  task automatic access(input logic ch, input logic [2:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clock_i);
    #1;
    cs_o = 1'b1;
    rd_o = !w;
    wr_o = w;
    chsel_o = ch;
    addr_o = a;
    wdata_o = d;
    @(posedge clock_i);
    #1;
    q = (w || rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule // host_bus_model

`default_nettype wire

// ### bench/dual_uart_register_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none

module dual_uart_register_decode_bench;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] rx_push = 2'h0;
  logic [1:0][7:0] rx_data = '0;
  wire logic cs, rd, wr, chsel, rd_valid;
  wire logic [2:0] addr;
  wire logic [7:0] wdata, rd_data;
  wire logic [1:0] tx_load, rts_n, dtr_n, mf, brk;
  wire logic [1:0][7:0] tx_data;
  wire logic [1:0][3:0] cbits, fbits;
  wire logic [1:0][15:0] div;
  int error_cnt = 0;
  int n_tests = 0;

  always #2.5 clock_i = ~clock_i;

  dual_uart_register_decode uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .cs_i(cs), .rd_i(rd),
    .wr_i(wr), .channel_select_i(chsel), .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .rx_push_i(rx_push), .rx_data_i(rx_data), .rx_error_i(6'h00), .tx_taken_i(2'h0),
    .tx_idle_i(2'h0), .tx_load_o(tx_load), .tx_data_o(tx_data), .modem_n_i(8'hFF), .rts_n_o(rts_n),
    .dtr_n_o(dtr_n), .multi_function_o(mf), .set_break_o(brk), .char_bits_o(cbits), .frame_bits_o(fbits),
    .divisor_o(div));

  host_bus_model host (.clock_i(clock_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .cs_o(cs), .rd_o(rd),
    .wr_o(wr), .chsel_o(chsel), .addr_o(addr), .wdata_o(wdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(ch, a, 1'b1, d, q);
  endtask

  task automatic rd_reg(input logic ch, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.access(ch, a, 1'b0, 8'h00, q);
    chk("read data", {8'h00, exp}, {8'h00, q});
  endtask

  // Registered pins lag their register by one edge; wait before sampling them
  task automatic settle();
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  task automatic pin_chk(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask

  function automatic logic [3:0] char_len(input logic [7:0] line_control);
    return 4'h5 + {2'h0, line_control[1:0]};
  endfunction

  function automatic logic [3:0] frame_len(input logic [7:0] line_control);
    return 4'h1 + char_len(line_control) + {3'h0, line_control[3]} + (line_control[2] ? 4'h2 : 4'h1);
  endfunction

  function automatic logic [7:0] word_mask(input logic [7:0] line_control, input logic [7:0] d);
    return d & (8'hFF >> (2'h3 - line_control[1:0]));
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A run needs a few hundred cycles; this bound leaves wide margin
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic ch;
    int i;
    logic [7:0] line_control, r;
    logic [15:0] d;
    logic [7:0] s [2];
    void'($urandom(32'h9705));
    repeat (16) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    for (int c = 0; c < 2; c++) begin
      ch = c[0];
      i = ch ? 0 : 1;
      rd_reg(ch, 3'h5, 8'h60);
      rd_reg(ch, 3'h3, 8'h00);
      rd_reg(ch, 3'h4, 8'h00);
      rd_reg(ch, 3'h1, 8'h00);
      rd_reg(ch, 3'h2, 8'h01);
      settle();
      pin_chk("mf general", 1'b1, mf[i]);
      s[c] = 8'($urandom);
      wr_reg(ch, 3'h7, s[c]);
    end
    for (int c = 0; c < 2; c++) rd_reg(c[0], 3'h7, s[c]);
    for (int c = 0; c < 2; c++) begin
      ch = c[0];
      i = ch ? 0 : 1;
      for (int k = 0; k < 16; k++) begin
        line_control = 8'(k);
        wr_reg(ch, 3'h3, line_control);
        settle();
        pin_chk("char bits", 1'b1, cbits[i] === char_len(line_control));
        chk("frame bits", {12'h0, frame_len(line_control)}, {12'h0, fbits[i]});
      end
      d = 16'($urandom);
      wr_reg(ch, 3'h3, 8'h83);
      wr_reg(ch, 3'h0, d[7:0]);
      wr_reg(ch, 3'h1, d[15:8]);
      chk("divisor", d, div[i]);
      rd_reg(ch, 3'h0, d[7:0]);
      rd_reg(ch, 3'h1, d[15:8]);
      rd_reg(ch, 3'h3, 8'h83);
      wr_reg(ch, 3'h2, 8'h04);
      rd_reg(ch, 3'h2, 8'h04);
      line_control = 8'($urandom) & 8'h03;
      wr_reg(ch, 3'h3, line_control);
      rd_reg(ch, 3'h2, 8'h01);
      // offset 0 data path, receive ready pin
      r = 8'($urandom);
      wr_reg(ch, 3'h0, r);
      chk("tx load", 16'h0001, {15'h0, tx_load[i]});
      chk("tx data", {8'h00, word_mask(line_control, r)}, {8'h00, tx_data[i]});
      chk("divisor kept", d, div[i]);
      r = 8'($urandom);
      rx_data[i] = r;
      rx_push[i] = 1'b1;
      @(posedge clock_i);
      #1 rx_push[i] = 1'b0;
      settle();
      pin_chk("mf ready", 1'b0, mf[i]);
      rd_reg(ch, 3'h0, word_mask(line_control, r));
      settle();
      pin_chk("mf ready", 1'b1, mf[i]);
      wr_reg(ch, 3'h3, 8'h83);
      wr_reg(ch, 3'h2, 8'h00);
      wr_reg(ch, 3'h3, 8'h03);
      wr_reg(ch, 3'h4, 8'h0B);
      settle();
      pin_chk("mf general", 1'b0, mf[i]);
      pin_chk("rts pin", 1'b0, rts_n[i]);
      pin_chk("dtr pin", 1'b0, dtr_n[i]);
      pin_chk("break pin", 1'b0, brk[i]);
    end
    end_of_test();
  end
endmodule // dual_uart_register_decode_bench

`default_nettype wire
